// ==== design/host_power_controller.sv ====
// Host-side controller that drives the module's open-collector control lines.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_map.svh"
module host_power_controller
    import pwr_seq_pkg::*;
#(
    parameter int unsigned ON_HOLD_CYC   = `MS_TO_CYC(`T_PWRKEY_ON_MS),
    parameter int unsigned OFF_HOLD_CYC  = `MS_TO_CYC(`T_TOGGLE_OFF_MS),
    parameter int unsigned HARD_HOLD_CYC = `MS_TO_CYC(`T_HARD_PULSE_MS),
    parameter int unsigned SETTLE_CYC    = `MS_TO_CYC(`T_ACTIVATE_MS),
    parameter int unsigned TIMEOUT_CYC   = `MS_TO_CYC(`T_PG_TIMEOUT_MS)
) (
    input  wire logic      mclk,
    input  wire logic      rst_n,
    pwr_seq_if.host        pins,
    input  wire host_cmd_t cmd,
    input  wire logic      emerg_restart,
    input  wire logic      emerg_shutdown,
    output var  logic      busy,
    output var  logic      ready,
    output var  logic      timeout
);
    // ------------------------------------------------------------
    // Sequencing.
    // ------------------------------------------------------------
    host_state_t state_q;
    logic [31:0] cnt_q;
    logic        hard_rst_q;

    // One counter times every hold and wait in turn.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= H_IDLE;
            cnt_q      <= 32'h0;
            hard_rst_q <= 1'b0;
            timeout    <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            case (state_q)
                H_IDLE, H_READY: begin
                    if (emerg_shutdown || emerg_restart) begin
                        state_q    <= H_HARD;
                        hard_rst_q <= emerg_restart && !emerg_shutdown;
                        cnt_q      <= 32'h0;
                    end else if ((cmd == CMD_ON && !pins.power_good_monitor)
                                 || (cmd == CMD_OFF && pins.power_good_monitor)) begin
                        state_q <= H_PRESS;
                        cnt_q   <= 32'h0;
                        timeout <= 1'b0;
                    end
                end
                H_PRESS: begin
                    // Power-off press is longer, so the module sees over two seconds.
                    if (cnt_q >= (pins.power_good_monitor ? OFF_HOLD_CYC : ON_HOLD_CYC)) begin
                        state_q <= pins.power_good_monitor ? H_WAIT_OFF : H_WAIT_PG;
                        cnt_q   <= 32'h0;
                    end
                end
                H_WAIT_PG: begin
                    if (pins.power_good_monitor) begin
                        state_q <= H_SETTLE;
                        cnt_q   <= 32'h0;
                    end else if (cnt_q >= TIMEOUT_CYC) begin
                        state_q <= H_IDLE;
                        timeout <= 1'b1;
                    end
                end
                H_SETTLE: begin
                    if (!pins.power_good_monitor) begin
                        state_q <= H_IDLE;
                    end else if (cnt_q >= SETTLE_CYC) begin
                        state_q <= H_READY;
                    end
                end
                H_WAIT_OFF: begin
                    if (!pins.power_good_monitor) begin
                        state_q <= H_IDLE;
                    end else if (cnt_q >= TIMEOUT_CYC) begin
                        state_q <= H_READY;
                        timeout <= 1'b1;
                    end
                end
                H_HARD: begin
                    if (cnt_q >= HARD_HOLD_CYC) begin
                        state_q <= hard_rst_q ? H_WAIT_PG : H_IDLE;
                        cnt_q   <= 32'h0;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive.
    // ------------------------------------------------------------
    // Open-collector only: drive low or release, never drive high.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pins.power_key_n_out     <= 1'b0;
            pins.power_key_n_oe      <= 1'b0;
            pins.hard_restart_n_out  <= 1'b0;
            pins.hard_restart_n_oe   <= 1'b0;
            pins.hard_shutdown_n_out <= 1'b0;
            pins.hard_shutdown_n_oe  <= 1'b0;
        end else begin
            pins.power_key_n_out     <= 1'b0;
            pins.power_key_n_oe      <= (state_q == H_PRESS);
            pins.hard_restart_n_out  <= 1'b0;
            pins.hard_restart_n_oe   <= (state_q == H_HARD) && hard_rst_q;
            pins.hard_shutdown_n_out <= 1'b0;
            pins.hard_shutdown_n_oe  <= (state_q == H_HARD) && !hard_rst_q;
        end
    end

    // Status towards the host's own logic.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy  <= 1'b0;
            ready <= 1'b0;
        end else begin
            busy  <= (state_q != H_IDLE) && (state_q != H_READY);
            ready <= (state_q == H_READY);
        end
    end
endmodule
`default_nettype wire

// ==== shared/pwr_seq_map.svh ====
// Offsets-free timing constants for the module power sequencer ends.
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH
`define CLK_FREQ_HZ        100000000
`define T_PWRKEY_ON_MS     1000
`define T_TOGGLE_OFF_MS    2000
`define T_HARD_PULSE_MS    200
`define T_BOOT_MS          10000
`define T_ACTIVATE_MS      15000
`define T_FINALIZE_MS      10000
`define T_PG_TIMEOUT_MS    60000
`define MS_TO_CYC(ms)      ((ms) * (`CLK_FREQ_HZ / 1000))
`endif

// ==== shared/pwr_seq_pkg.sv ====
// Types shared by both ends of the module power sequencer.
package pwr_seq_pkg;
    typedef enum logic [5:0] {
        DEV_OFF   = 6'h01,
        DEV_INIT  = 6'h02,
        DEV_ACT   = 6'h04,
        DEV_FINAL = 6'h08,
        DEV_RESTART = 6'h10,
        DEV_SPARE = 6'h20
    } dev_state_t;
    typedef enum logic [6:0] {
        H_IDLE    = 7'h01,
        H_PRESS   = 7'h02,
        H_WAIT_PG = 7'h04,
        H_SETTLE  = 7'h08,
        H_READY   = 7'h10,
        H_WAIT_OFF = 7'h20,
        H_HARD    = 7'h40
    } host_state_t;
    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_ON   = 2'h1,
        CMD_OFF  = 2'h2
    } host_cmd_t;
endpackage

// ==== shared/pwr_seq_if.sv ====
// Control pins between the host controller and the cellular module.
`timescale 1ns/1ps
`default_nettype none
interface pwr_seq_if;
    logic power_key_n_out;    // Host pulls power-key low.
    logic power_key_n_oe;
    logic hard_restart_n_out;
    logic hard_restart_n_oe;
    logic hard_shutdown_n_out;
    logic hard_shutdown_n_oe;
    logic power_good_monitor; // Module drives power-good.
    // Open-collector lines with internal pull-up inside the module.
    logic power_key_n;
    logic hard_restart_n;
    logic hard_shutdown_n;
    assign power_key_n     = (power_key_n_oe && !power_key_n_out) ? 1'b0 : 1'b1;
    assign hard_restart_n  = (hard_restart_n_oe && !hard_restart_n_out) ? 1'b0 : 1'b1;
    assign hard_shutdown_n = (hard_shutdown_n_oe && !hard_shutdown_n_out) ? 1'b0 : 1'b1;
    modport host (
        output power_key_n_out, power_key_n_oe,
        output hard_restart_n_out, hard_restart_n_oe,
        output hard_shutdown_n_out, hard_shutdown_n_oe,
        input  power_good_monitor
    );
    modport device (
        input  power_key_n, hard_restart_n, hard_shutdown_n,
        output power_good_monitor
    );
endinterface
`default_nettype wire

// ==== design/module_power_sequencer.sv ====
// Module-side power sequencer: power key, finalization and hard paths.
//
// Overview of operation
// - host holds power key low one second
// - boot sequence takes about ten seconds
// - host waits fifteen seconds after power-good
// - no commands accepted while initializing
// - power-good goes high once powered on
// - software shutdown finalizes, then power-good drops
// - host detects power-off from power-good falling
// - host holds toggle low two seconds
// - toggle held over two seconds starts finalization
// - detach request only on orderly shutdowns
// - host holds hard restart low 200 ms
// - host holds hard shutdown low 200 ms
// - host drives power key open-collector only
// - hard paths are emergency exits only
// - host releases all pins (pulled high) while module off, except the power-on key press; emerg_restart or emerg_shutdown in H_IDLE still pulls a hard line low
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_map.svh"
module module_power_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int unsigned ON_HOLD_CYC   = `MS_TO_CYC(`T_PWRKEY_ON_MS),
    parameter int unsigned OFF_HOLD_CYC  = `MS_TO_CYC(`T_TOGGLE_OFF_MS),
    parameter int unsigned HARD_HOLD_CYC = `MS_TO_CYC(`T_HARD_PULSE_MS),
    parameter int unsigned BOOT_CYC      = `MS_TO_CYC(`T_BOOT_MS),
    parameter int unsigned FINAL_CYC     = `MS_TO_CYC(`T_FINALIZE_MS)
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    pwr_seq_if.device pins,
    input  wire logic sw_shutdown,
    output var  logic cmd_ready,
    output var  logic detach_req,
    output var  logic powered
);
    // ------------------------------------------------------------
    // Hold-time measurement of the three control lines.
    // ------------------------------------------------------------
    // Counters saturate so a very long press never wraps into a short one.
    logic [31:0] key_cnt_q;
    logic [31:0] rst_cnt_q;
    logic [31:0] shd_cnt_q;
    logic        key_low_q;
    logic        key_rel;
    logic        rst_rel;
    logic        shd_rel;
    dev_state_t  state_q;
    logic [31:0] tmr_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key_cnt_q <= 32'h0;
            rst_cnt_q <= 32'h0;
            shd_cnt_q <= 32'h0;
            key_low_q <= 1'b0;
        end else begin
            key_low_q <= !pins.power_key_n;
            key_cnt_q <= !pins.power_key_n ? ((key_cnt_q == 32'hFFFFFFFF) ? key_cnt_q : key_cnt_q + 32'h1) : 32'h0;
            rst_cnt_q <= !pins.hard_restart_n ? ((rst_cnt_q == 32'hFFFFFFFF) ? rst_cnt_q : rst_cnt_q + 32'h1) : 32'h0;
            shd_cnt_q <= !pins.hard_shutdown_n ? ((shd_cnt_q == 32'hFFFFFFFF) ? shd_cnt_q : shd_cnt_q + 32'h1) : 32'h0;
        end
    end

    // A press is acted on at its release, once it was long enough.
    assign key_rel = pins.power_key_n && key_low_q;
    assign rst_rel = pins.hard_restart_n && (rst_cnt_q >= HARD_HOLD_CYC);
    assign shd_rel = pins.hard_shutdown_n && (shd_cnt_q >= HARD_HOLD_CYC);

    // ------------------------------------------------------------
    // Power state machine.
    // ------------------------------------------------------------
    // Unconditional shutdown outranks restart, which outranks the rest.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DEV_OFF;
            tmr_q   <= 32'h0;
        end else begin
            tmr_q <= tmr_q + 32'h1;
            if (shd_rel && state_q != DEV_OFF) begin
                state_q <= DEV_OFF;
            end else if (rst_rel && state_q != DEV_OFF) begin
                state_q <= DEV_RESTART;
                tmr_q   <= 32'h0;
            end else begin
                case (state_q)
                    DEV_OFF: begin
                        if (key_rel && key_cnt_q >= ON_HOLD_CYC) begin
                            state_q <= DEV_INIT;
                            tmr_q   <= 32'h0;
                        end
                    end
                    DEV_INIT, DEV_RESTART: begin
                        if (tmr_q >= BOOT_CYC - 1) begin
                            state_q <= DEV_ACT;
                            tmr_q   <= 32'h0;
                        end
                    end
                    DEV_ACT: begin
                        if (sw_shutdown || (key_rel && key_cnt_q > OFF_HOLD_CYC)) begin
                            state_q <= DEV_FINAL;
                            tmr_q   <= 32'h0;
                        end
                    end
                    DEV_FINAL: begin
                        if (tmr_q >= FINAL_CYC - 1) begin
                            state_q <= DEV_OFF;
                        end
                    end
                    default: state_q <= DEV_OFF;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs.
    // ------------------------------------------------------------
    // Power-good stays high through finalization and drops when it ends.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pins.power_good_monitor <= 1'b0;
            powered                 <= 1'b0;
        end else begin
            pins.power_good_monitor <= (state_q != DEV_OFF);
            powered                 <= (state_q != DEV_OFF);
        end
    end

    // Commands only once the activation state is reached.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= (state_q == DEV_ACT);
        end
    end

    // Detach is a one-cycle pulse on entry to finalization only.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            detach_req <= 1'b0;
        end else begin
            detach_req <= (state_q == DEV_ACT) && !shd_rel && !rst_rel
                          && (sw_shutdown || (key_rel && key_cnt_q > OFF_HOLD_CYC));
        end
    end
endmodule
`default_nettype wire

// ==== bench/pwr_seq_properties.sv ====
// Checker for the control pins between the host controller and the module.
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_properties #(
    parameter int unsigned ON_HOLD_CYC   = 10,
    parameter int unsigned OFF_HOLD_CYC  = 20,
    parameter int unsigned HARD_HOLD_CYC = 5
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_key_n_out,
    input wire logic power_key_n_oe,
    input wire logic hard_restart_n_out,
    input wire logic hard_restart_n_oe,
    input wire logic hard_shutdown_n_out,
    input wire logic hard_shutdown_n_oe,
    input wire logic power_good_monitor,
    input wire logic power_key_n,
    input wire logic hard_restart_n,
    input wire logic hard_shutdown_n
);
    // ------------------------------------------------------------
    // Hold counters
    // ------------------------------------------------------------
    int unsigned key_cnt_q;
    int unsigned rst_cnt_q;
    int unsigned sd_cnt_q;
    // Each counter holds the number of clock cycles its line has been pulled so far.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key_cnt_q <= 0;
            rst_cnt_q <= 0;
            sd_cnt_q  <= 0;
        end else begin
            key_cnt_q <= power_key_n_oe ? key_cnt_q + 1 : 0;
            rst_cnt_q <= hard_restart_n_oe ? rst_cnt_q + 1 : 0;
            sd_cnt_q  <= hard_shutdown_n_oe ? sd_cnt_q + 1 : 0;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // One domain, so the clock and the reset are given once here.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_key_hold;
        $fell(power_key_n_oe) |-> key_cnt_q == (power_good_monitor ? OFF_HOLD_CYC + 1 : ON_HOLD_CYC + 1);
    endproperty
    a_key_hold: assert property (p_key_hold) else $error("power key hold length off");
    property p_restart_hold;
        $fell(hard_restart_n_oe) |-> rst_cnt_q == HARD_HOLD_CYC + 1;
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("restart hold length off");
    property p_shut_hold;
        $fell(hard_shutdown_n_oe) |-> sd_cnt_q == HARD_HOLD_CYC + 1;
    endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("shutdown hold length off");
    property p_open_drain;
        !power_key_n_out && !hard_restart_n_out && !hard_shutdown_n_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("host drives a line high");
    property p_pg_rise;
        $rose(power_good_monitor) |-> $past(power_key_n, 2) && !$past(power_key_n, 3);
    endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("power good rose without key release");
    property p_pg_after_on;
        $fell(power_key_n_oe) && !power_good_monitor |-> ##2 $rose(power_good_monitor);
    endproperty
    a_pg_after_on: assert property (p_pg_after_on) else $error("power good late after key");
    property p_final;
        $fell(power_key_n_oe) && power_good_monitor |-> power_good_monitor [*8] ##[16:40] !power_good_monitor;
    endproperty
    a_final: assert property (p_final) else $error("finalization length off");
    property p_restart_keeps;
        $rose(hard_restart_n) && power_good_monitor |-> power_good_monitor [*8];
    endproperty
    a_restart_keeps: assert property (p_restart_keeps) else $error("restart dropped power good");
    property p_hard_off;
        $fell(hard_shutdown_n_oe) && power_good_monitor |-> ##[1:4] !power_good_monitor;
    endproperty
    a_hard_off: assert property (p_hard_off) else $error("hard shutdown kept power good");
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the host controller and module sequencer on one link.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pwr_seq_pkg::*;
    localparam int unsigned BOOT      = 30;
    localparam int unsigned ON_HOLD   = 10;
    localparam int unsigned OFF_HOLD  = 20;
    localparam int unsigned HARD_HOLD = 5;
    localparam int unsigned SETTLE    = 40;
    localparam int unsigned TMO       = 200;
    localparam int unsigned FINAL     = 30;
    logic        mclk, rst_n, dev_en, dev_rst_n;
    host_cmd_t   cmd;
    logic        emerg_restart, emerg_shutdown, sw_shutdown;
    logic        busy, ready, timeout, cmd_ready, detach_req, powered;
    logic [4:0]  flags;
    logic [1:0]  exp_q[$];
    logic [1:0]  obs_last = 2'b00;
    logic [31:0] lfsr_q = 32'h9bcb;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          n;
    // The module has its own reset so the host can be left without an answer.
    assign dev_rst_n = rst_n & dev_en;
    assign flags = {busy, timeout, ready, cmd_ready, powered};
    pwr_seq_if link ();
    host_power_controller #(.ON_HOLD_CYC(ON_HOLD), .OFF_HOLD_CYC(OFF_HOLD), .HARD_HOLD_CYC(HARD_HOLD),
        .SETTLE_CYC(SETTLE), .TIMEOUT_CYC(TMO)) host_power_controller_inst (.mclk(mclk), .rst_n(rst_n),
        .pins(link.host),
        .cmd(cmd), .emerg_restart(emerg_restart), .emerg_shutdown(emerg_shutdown), .busy(busy),
        .ready(ready), .timeout(timeout));
    module_power_sequencer #(.ON_HOLD_CYC(ON_HOLD), .OFF_HOLD_CYC(OFF_HOLD), .HARD_HOLD_CYC(HARD_HOLD),
        .BOOT_CYC(BOOT), .FINAL_CYC(FINAL)) module_power_sequencer_inst (.mclk(mclk), .rst_n(dev_rst_n),
        .pins(link.device),
        .sw_shutdown(sw_shutdown), .cmd_ready(cmd_ready), .detach_req(detach_req), .powered(powered));
    pwr_seq_properties #(.ON_HOLD_CYC(ON_HOLD), .OFF_HOLD_CYC(OFF_HOLD), .HARD_HOLD_CYC(HARD_HOLD))
        pwr_seq_properties_inst (
        .mclk(mclk), .rst_n(dev_rst_n), .power_key_n_out(link.power_key_n_out),
        .power_key_n_oe(link.power_key_n_oe), .hard_restart_n_out(link.hard_restart_n_out),
        .hard_restart_n_oe(link.hard_restart_n_oe), .hard_shutdown_n_out(link.hard_shutdown_n_out),
        .hard_shutdown_n_oe(link.hard_shutdown_n_oe), .power_good_monitor(link.power_good_monitor),
        .power_key_n(link.power_key_n), .hard_restart_n(link.hard_restart_n),
        .hard_shutdown_n(link.hard_shutdown_n));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", name, e, s);
        end
    endtask
    function automatic logic [31:0] lfsr_next();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    // Bounded wait on one flag; a flag that never arrives shows up as a mismatch.
    task automatic wait_flag(input int b, input logic v, output int k);
        k = 0;
        while (flags[b] !== v && k < 2000) begin
            @(negedge mclk);
            k++;
        end
        check("awaited flag", v, flags[b]);
    endtask
    task automatic host_cmd(input host_cmd_t c);
        @(posedge mclk);
        cmd <= c;
        @(posedge mclk);
        cmd <= CMD_NONE;
    endtask
    task automatic power_on();
        exp_q.push_back(2'b10);
        host_cmd(CMD_ON);
        // Ready may still stand from the last sequence, so see busy rise first.
        wait_flag(4, 1'b1, n);
        wait_flag(2, 1'b1, n);
    endtask
    // Waiting for busy to rise first keeps the wait for its fall from passing at once.
    task automatic emerg(input logic r, input logic s);
        @(posedge mclk);
        emerg_restart <= r;
        emerg_shutdown <= s;
        @(posedge mclk);
        emerg_restart <= 1'b0;
        emerg_shutdown <= 1'b0;
        wait_flag(4, 1'b1, n);
        wait_flag(4, 1'b0, n);
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and output monitor
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // The run needs well under ten thousand cycles; twice that means a hang.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    // Every change of power state or detach pulse must match the oldest note.
    always @(negedge mclk) begin
        if (dev_rst_n === 1'b1 && {powered, detach_req} !== obs_last) begin
            if (exp_q.size() == 0) check("unexpected event", obs_last, {powered, detach_req});
            else check("powered detach", exp_q.pop_front(), {powered, detach_req});
        end
        obs_last = {powered, detach_req};
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        dev_en = 1'b1;
        cmd = CMD_NONE;
        emerg_restart = 1'b0;
        emerg_shutdown = 1'b0;
        sw_shutdown = 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        exp_q.push_back(2'b10);
        host_cmd(CMD_ON);
        wait_flag(0, 1'b1, n);
        check("cmd_ready in init", 8'h00, cmd_ready);
        wait_flag(1, 1'b1, n);
        check("boot length", 8'h01, n >= BOOT - 1 && n <= BOOT + 1);
        wait_flag(2, 1'b1, n);
        check("ready after boot", 8'h01, cmd_ready);
        repeat (lfsr_next() % 8) @(posedge mclk);
        @(posedge mclk);
        exp_q.push_back(2'b11);
        exp_q.push_back(2'b10);
        exp_q.push_back(2'b00);
        sw_shutdown <= 1'b1;
        @(posedge mclk);
        sw_shutdown <= 1'b0;
        wait_flag(0, 1'b0, n);
        check("finalization held", 8'h01, n >= 29);
        power_on();
        exp_q.push_back(2'b11);
        exp_q.push_back(2'b10);
        exp_q.push_back(2'b00);
        host_cmd(CMD_OFF);
        wait_flag(0, 1'b0, n);
        wait_flag(4, 1'b0, n);
        power_on();
        emerg(1'b1, 1'b0);
        wait_flag(1, 1'b1, n);
        check("powered after restart", 8'h01, powered);
        exp_q.push_back(2'b00);
        emerg(1'b1, 1'b1);
        wait_flag(0, 1'b0, n);
        check("powered after hard off", 8'h00, powered);
        @(posedge mclk);
        dev_en <= 1'b0;
        host_cmd(CMD_ON);
        wait_flag(3, 1'b1, n);
        check("ready on timeout", 8'h00, ready);
        @(posedge mclk);
        dev_en <= 1'b1;
        power_on();
        check("timeout cleared", 8'h00, timeout);
        end_of_test();
    end
endmodule
`default_nettype wire
